// >>> design/codec_timing_pkg.sv
`default_nettype none
package codec_timing_pkg;
    localparam logic [3:0]  LAST_BIT        = 4'hf;
    localparam logic [3:0]  LAST_GAP_SHIFT  = 4'h3;
    localparam logic [1:0]  SAMPLE_PHASE    = 2'h1;

    localparam logic [4:0]  COARSE_RESET    = 5'h09;
    localparam logic [5:0]  TRIM_RESET      = 6'h01;
    localparam logic [6:0]  FINE_RESET      = 7'h24;
    localparam logic [5:0]  CONTROL_RESET   = 6'h39;
    localparam logic [4:0]  MIN_LEGAL       = 5'h02;
    localparam logic [7:0]  MODULO_FIX      = 8'h40;

    localparam logic [1:0]  LOAD_PLAIN      = 2'h0;
    localparam logic [1:0]  LOAD_PLUS       = 2'h1;
    localparam logic [1:0]  LOAD_MINUS      = 2'h2;
    localparam logic [1:0]  LOAD_SECONDARY  = 2'h3;

    localparam logic [1:0]  SEL_COARSE      = 2'h0;
    localparam logic [1:0]  SEL_TRIM        = 2'h1;
    localparam logic [1:0]  SEL_FINE        = 2'h2;
    localparam logic [1:0]  SEL_CONTROL     = 2'h3;

    localparam int          DAC_LSB         = 2;
    localparam int          TX_COARSE_LSB   = 9;
    localparam int          RX_COARSE_LSB   = 2;
    localparam int          TX_TRIM_LSB     = 9;
    localparam int          RX_TRIM_LSB     = 2;
    localparam int          TX_FINE_LSB     = 8;
    localparam int          RX_FINE_LSB     = 2;
    localparam int          CONTROL_LSB     = 2;

    localparam int          CTRL_BANDPASS   = 0;
    localparam int          CTRL_LOOPBACK   = 1;
    localparam int          CTRL_AUX        = 2;
    localparam int          CTRL_SYNC       = 3;
    localparam int          CTRL_GAIN_LSB   = 4;

    typedef enum logic [1:0] {
        FRAME_IDLE,
        FRAME_PRIMARY,
        FRAME_GAP,
        FRAME_SECONDARY
    } frame_state_t;
endpackage
`default_nettype wire

// >>> design/pin_sync2.sv
`default_nettype none
module pin_sync2 (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic first_stage;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            first_stage <= 1'b0;
            sync_o      <= 1'b0;
        end else begin
            first_stage <= async_i;
            sync_o      <= first_stage;
        end
    end
endmodule
`default_nettype wire

// >>> design/conversion_period_timer.sv
`default_nettype none
// two coarse segments per filter clock, fine_i of those per period
module conversion_period_timer (
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic [6:0] coarse_i,
    input  wire logic [6:0] trimmed_i,
    input  wire logic [6:0] fine_i,
    input  wire logic       adjust_i,
    output logic            filter_tick_o,
    output logic            period_end_o,
    output logic            adjust_taken_o
);
    logic [6:0] seg_cnt;
    logic [7:0] half_cnt;

    wire       seg_done    = (seg_cnt <= 7'h01);
    wire [7:0] last_half   = {fine_i, 1'b0} - 8'h01;
    wire       period_done = (half_cnt >= last_half);
    wire [7:0] next_half   = period_done ? 8'h00 : half_cnt + 8'h01;
    // trim the final segment only
    wire       take_adjust = seg_done & adjust_i & (next_half == last_half);

    assign filter_tick_o  = seg_done;
    assign period_end_o   = seg_done & period_done;
    assign adjust_taken_o = take_adjust;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            seg_cnt  <= {2'h0, codec_timing_pkg::COARSE_RESET};
            half_cnt <= 8'h00;
        end else if (seg_done) begin
            half_cnt <= next_half;
            seg_cnt  <= take_adjust ? trimmed_i : coarse_i;
        end else begin
            seg_cnt <= seg_cnt - 7'h01;
        end
    end
endmodule
`default_nettype wire

// >>> design/codec_conversion_timing_control.sv
// How it works
// [R01] reset gives 8 kHz at 5.184 MHz
// [R02] reset: coarse 9, trim 1, fine 24 hex, both ways
// [R03] reset sets control bits 7,6,5,2, clears 4,3
// [R04] sync mode times both ways from transmit registers
// [R05] tx trimmed coarse of 0 or 1 loads untrimmed
// [R06] negative tx trimmed coarse gets 40 hex added
// [R07] rx trimmed coarse of 0 or 1 loads untrimmed
// [R08] negative rx trimmed coarse gets 40 hex added
// [R09] coarse of 0 or 1 shuts conversion down
// [R10] fine written 0 or 1 becomes 24 hex
// [R11] D/A output holds its last value
// [R12] host keeps coarse, fine, trimmed coarse above 1
// [R13] trims are signed two's complement
// [R14] host spaces D/A frames at least 1/19.2 kHz
// [R15] host sends each adjust in its own frame
// [R16] one adjust alters one tx and one rx period
// [R17] trim lands near the period end
// [R18] rx adjust: current period if time remains, else next
// [R19] rx adjust ignored if period adjusted or scheduled
// [R20] tx and control secondary values act at once
// [R21] later rx values in an applied period dropped
// [R22] control: bandpass, loopback, aux, sync, gain
// [R23] filter clock master over twice coarse, rate over fine
// [R24] primary low bits: plain, plus, minus, secondary
// [R25] rx counters and registers unused in sync mode; rx coarse below 2 still shuts conversion down
// [R26] shutdown lasts until legal write or reset
`default_nettype none
module codec_conversion_timing_control (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        serial_word_in_i,
    input  wire logic [15:0] adc_word_i,
    output logic             shift_clock_o,
    output logic             transmit_frame_sync_n_o,
    output logic             receive_frame_sync_n_o,
    output logic             serial_word_out_o,
    output logic [13:0]      dac_word_o,
    output logic             dac_strobe_o,
    output logic             adc_strobe_o,
    output logic             tx_filter_clock_o,
    output logic             rx_filter_clock_o,
    output logic             shutdown_o,
    output logic             bandpass_insert_o,
    output logic             loopback_enable_o,
    output logic             aux_input_enable_o,
    output logic             sync_mode_o,
    output logic [1:0]       input_gain_o
);
    logic [4:0]  tx_coarse_divider;
    logic [5:0]  tx_period_trim;
    logic [6:0]  tx_fine_divider;
    logic [4:0]  rx_coarse_divider;
    logic [5:0]  rx_period_trim;
    logic [6:0]  rx_fine_divider;
    logic [5:0]  mode_control;

    logic        din_sync;
    logic [1:0]  phase;
    logic [14:0] in_shift;
    logic [3:0]  bit_cnt;
    logic [13:0] dac_latch;
    logic        tx_req;
    logic        tx_adj_pend;
    logic        tx_adj_minus;
    logic        rx_adj_pend;
    logic        rx_adj_minus;
    logic        rx_adj_done;
    logic        rx_written;
    logic        rx_req;
    logic        rx_busy;
    logic [3:0]  rx_cnt;
    logic [15:0] out_shift;
    codec_timing_pkg::frame_state_t state;
    codec_timing_pkg::frame_state_t next_state;

    wire tx_tick;
    wire tx_end;
    wire tx_taken;
    wire rx_tick;
    wire rx_end;
    wire rx_taken;

    function automatic logic [6:0] coarse_load(input logic [4:0] base,
                                               input logic [5:0] trim,
                                               input logic       minus);
        logic signed [7:0] sum;
        logic signed [7:0] trim_ext;
        trim_ext = $signed({{2{trim[5]}}, trim}); // [R13]
        sum = minus ? $signed({3'h0, base}) - trim_ext : $signed({3'h0, base}) + trim_ext;
        if (sum == 8'sh00 || sum == 8'sh01) begin
            coarse_load = {2'h0, base};                          // [R05] [R07]
        end else if (sum < 8'sh00) begin
            coarse_load = 7'(sum + $signed(codec_timing_pkg::MODULO_FIX)); // [R06] [R08]
        end else begin
            coarse_load = sum[6:0];
        end
    endfunction

    pin_sync2 u_din_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i (serial_word_in_i),
        .sync_o  (din_sync)
    );

    wire [6:0] tx_trimmed = coarse_load(tx_coarse_divider, tx_period_trim, tx_adj_minus);
    wire [6:0] rx_trimmed = coarse_load(rx_coarse_divider, rx_period_trim, rx_adj_minus);

    // [R23] filter clock and conversion period from coarse and fine counters
    conversion_period_timer u_tx_timer (
        .clock_i        (clock_i),
        .reset_i        (reset_i),
        .coarse_i       ({2'h0, tx_coarse_divider}),
        .trimmed_i      (tx_trimmed),
        .fine_i         (tx_fine_divider),
        .adjust_i       (tx_adj_pend),
        .filter_tick_o  (tx_tick),
        .period_end_o   (tx_end),
        .adjust_taken_o (tx_taken)
    );

    conversion_period_timer u_rx_timer (
        .clock_i        (clock_i),
        .reset_i        (reset_i),
        .coarse_i       ({2'h0, rx_coarse_divider}),
        .trimmed_i      (rx_trimmed),
        .fine_i         (rx_fine_divider),
        .adjust_i       (rx_adj_pend),
        .filter_tick_o  (rx_tick),
        .period_end_o   (rx_end),
        .adjust_taken_o (rx_taken)
    );

    wire        sync_mode   = mode_control[codec_timing_pkg::CTRL_SYNC];
    // [R04] [R25] sync mode ignores the rx timer
    wire        adc_end     = sync_mode ? tx_end : rx_end;
    wire        adc_tick    = sync_mode ? tx_tick : rx_tick;
    wire        rx_async_end = ~sync_mode & rx_end;
    wire        sample_en   = (phase == codec_timing_pkg::SAMPLE_PHASE);
    wire [15:0] full_word   = {in_shift, din_sync};
    wire [1:0]  low_bits    = full_word[1:0];
    wire        shifting    = (state == codec_timing_pkg::FRAME_PRIMARY) ||
                              (state == codec_timing_pkg::FRAME_SECONDARY);
    wire        word_done   = sample_en & shifting & (bit_cnt == codec_timing_pkg::LAST_BIT);
    wire        primary_done   = word_done & (state == codec_timing_pkg::FRAME_PRIMARY);
    wire        secondary_done = word_done & (state == codec_timing_pkg::FRAME_SECONDARY);
    wire        tx_start    = sample_en & (state == codec_timing_pkg::FRAME_IDLE) & tx_req;
    // [R24] plus and minus trim requests
    wire        adj_cmd     = primary_done & ((low_bits == codec_timing_pkg::LOAD_PLUS) ||
                                              (low_bits == codec_timing_pkg::LOAD_MINUS));
    wire        rx_adj_cmd  = adj_cmd & ~sync_mode & ~rx_adj_pend & ~rx_adj_done; // [R19]
    wire        sec_rx_write = secondary_done & (low_bits != codec_timing_pkg::SEL_CONTROL);
    wire        rx_accept   = ~rx_written;                                    // [R21]
    wire        rx_start    = sync_mode ? tx_start : (sample_en & rx_req & ~rx_busy);
    wire        illegal     = (tx_coarse_divider < codec_timing_pkg::MIN_LEGAL) ||
                              (rx_coarse_divider < codec_timing_pkg::MIN_LEGAL);
    wire [6:0]  tx_fine_new = full_word[codec_timing_pkg::TX_FINE_LSB +: 7];
    wire [6:0]  rx_fine_new = {1'b0, full_word[codec_timing_pkg::RX_FINE_LSB +: 6]};

    always_comb begin
        next_state = state;
        case (state)
            codec_timing_pkg::FRAME_IDLE: begin
                if (tx_start) begin
                    next_state = codec_timing_pkg::FRAME_PRIMARY;
                end
            end
            codec_timing_pkg::FRAME_PRIMARY: begin
                if (primary_done) begin
                    next_state = (low_bits == codec_timing_pkg::LOAD_SECONDARY) ?
                                 codec_timing_pkg::FRAME_GAP : codec_timing_pkg::FRAME_IDLE;
                end
            end
            codec_timing_pkg::FRAME_GAP: begin
                if (sample_en && bit_cnt == codec_timing_pkg::LAST_GAP_SHIFT) begin
                    next_state = codec_timing_pkg::FRAME_SECONDARY; // [R24]
                end
            end
            codec_timing_pkg::FRAME_SECONDARY: begin
                if (secondary_done) begin
                    next_state = codec_timing_pkg::FRAME_IDLE;
                end
            end
            default: next_state = codec_timing_pkg::FRAME_IDLE;
        endcase
    end

    // shift clock: master over four
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            phase         <= 2'h0;
            shift_clock_o <= 1'b0;
        end else begin
            phase         <= phase + 2'h1;
            shift_clock_o <= ~phase[1];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state                   <= codec_timing_pkg::FRAME_IDLE;
            bit_cnt                 <= 4'h0;
            in_shift                <= 15'h0000;
            transmit_frame_sync_n_o <= 1'b1;
        end else begin
            state                   <= next_state;
            transmit_frame_sync_n_o <= ~((next_state == codec_timing_pkg::FRAME_PRIMARY) ||
                                         (next_state == codec_timing_pkg::FRAME_SECONDARY));
            if (next_state != state) begin
                bit_cnt <= 4'h0;
            end else if (sample_en) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (sample_en && shifting) begin
                in_shift <= full_word[14:0];
            end
        end
    end

    // set beats clear
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tx_req       <= 1'b0;
            rx_req       <= 1'b0;
            tx_adj_pend  <= 1'b0;
            tx_adj_minus <= 1'b0;
            rx_adj_pend  <= 1'b0;
            rx_adj_minus <= 1'b0;
            rx_adj_done  <= 1'b0;
            rx_written   <= 1'b0;
        end else begin
            tx_req <= tx_end | (tx_req & ~tx_start);
            rx_req <= rx_async_end | (rx_req & ~(rx_start & ~sync_mode));
            // [R16] [R17] trim one last segment
            tx_adj_pend <= adj_cmd | (tx_adj_pend & ~tx_taken);
            if (adj_cmd) begin
                tx_adj_minus <= (low_bits == codec_timing_pkg::LOAD_MINUS);
            end
            // [R18] pending rolls over if its point passed
            rx_adj_pend <= rx_adj_cmd | (rx_adj_pend & ~rx_taken);
            if (rx_adj_cmd) begin
                rx_adj_minus <= (low_bits == codec_timing_pkg::LOAD_MINUS);
            end
            rx_adj_done <= rx_taken | (rx_adj_done & ~rx_end);       // [R19]
            rx_written  <= (sec_rx_write & rx_accept) | (rx_written & ~rx_end); // [R21]
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tx_coarse_divider <= codec_timing_pkg::COARSE_RESET; // [R01] [R02]
            tx_period_trim    <= codec_timing_pkg::TRIM_RESET;   // [R02]
            tx_fine_divider   <= codec_timing_pkg::FINE_RESET;   // [R02]
            rx_coarse_divider <= codec_timing_pkg::COARSE_RESET; // [R02]
            rx_period_trim    <= codec_timing_pkg::TRIM_RESET;   // [R02]
            rx_fine_divider   <= codec_timing_pkg::FINE_RESET;   // [R02]
            mode_control      <= codec_timing_pkg::CONTROL_RESET; // [R01] [R03]
        end else if (secondary_done) begin
            // [R20] tx and control always land
            case (low_bits)
                codec_timing_pkg::SEL_COARSE: begin
                    tx_coarse_divider <= full_word[codec_timing_pkg::TX_COARSE_LSB +: 5];
                    if (rx_accept) begin
                        rx_coarse_divider <= full_word[codec_timing_pkg::RX_COARSE_LSB +: 5];
                    end
                end
                codec_timing_pkg::SEL_TRIM: begin
                    tx_period_trim <= full_word[codec_timing_pkg::TX_TRIM_LSB +: 6];
                    if (rx_accept) begin
                        rx_period_trim <= full_word[codec_timing_pkg::RX_TRIM_LSB +: 6];
                    end
                end
                codec_timing_pkg::SEL_FINE: begin
                    tx_fine_divider <= (tx_fine_new < 7'h02) ?
                                       codec_timing_pkg::FINE_RESET : tx_fine_new; // [R10]
                    if (rx_accept) begin
                        rx_fine_divider <= (rx_fine_new < 7'h02) ?
                                           codec_timing_pkg::FINE_RESET : rx_fine_new; // [R10]
                    end
                end
                default: begin
                    mode_control <= full_word[codec_timing_pkg::CONTROL_LSB +: 6]; // [R22]
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            dac_latch         <= 14'h0000;
            dac_word_o        <= 14'h0000;
            dac_strobe_o      <= 1'b0;
            adc_strobe_o      <= 1'b0;
            tx_filter_clock_o <= 1'b0;
            rx_filter_clock_o <= 1'b0;
            shutdown_o        <= 1'b0;
        end else begin
            if (primary_done) begin
                dac_latch <= full_word[15:codec_timing_pkg::DAC_LSB];
            end
            // [R11] moves only at a conversion
            if (tx_end && !illegal) begin
                dac_word_o <= dac_latch;
            end
            dac_strobe_o <= tx_end & ~illegal;             // [R09]
            adc_strobe_o <= adc_end & ~illegal;            // [R09] [R04]
            if (tx_tick) begin
                tx_filter_clock_o <= ~tx_filter_clock_o;   // [R23]
            end
            if (adc_tick) begin
                rx_filter_clock_o <= ~rx_filter_clock_o;   // [R04]
            end
            shutdown_o <= illegal;                         // [R09] [R26]
        end
    end

    // converter word out
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rx_busy                <= 1'b0;
            rx_cnt                 <= 4'h0;
            out_shift              <= 16'h0000;
            serial_word_out_o      <= 1'b0;
            receive_frame_sync_n_o <= 1'b1;
        end else if (rx_start) begin
            rx_busy                <= 1'b1;
            rx_cnt                 <= 4'h0;
            out_shift              <= adc_word_i;
            serial_word_out_o      <= adc_word_i[15];
            receive_frame_sync_n_o <= 1'b0;
        end else if (sample_en && rx_busy) begin
            rx_cnt            <= rx_cnt + 4'h1;
            out_shift         <= {out_shift[14:0], 1'b0};
            serial_word_out_o <= out_shift[14];
            if (rx_cnt == codec_timing_pkg::LAST_BIT) begin
                rx_busy                <= 1'b0;
                receive_frame_sync_n_o <= 1'b1;
            end
        end
    end

    assign bandpass_insert_o  = mode_control[codec_timing_pkg::CTRL_BANDPASS];
    assign loopback_enable_o  = mode_control[codec_timing_pkg::CTRL_LOOPBACK];
    assign aux_input_enable_o = mode_control[codec_timing_pkg::CTRL_AUX];
    assign sync_mode_o        = mode_control[codec_timing_pkg::CTRL_SYNC];
    assign input_gain_o       = mode_control[codec_timing_pkg::CTRL_GAIN_LSB +: 2];
endmodule
`default_nettype wire

// >>> testbench/codec_timing_checker.sv
`default_nettype none
module codec_timing_checker (
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        transmit_frame_sync_n_o,
    input wire logic        receive_frame_sync_n_o,
    input wire logic [13:0] dac_word_o,
    input wire logic        dac_strobe_o,
    input wire logic        adc_strobe_o,
    input wire logic        shutdown_o,
    input wire logic        bandpass_insert_o,
    input wire logic        loopback_enable_o,
    input wire logic        aux_input_enable_o,
    input wire logic        sync_mode_o,
    input wire logic [1:0]  input_gain_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;
    wire  [5:0] ctrl = {input_gain_o, sync_mode_o, aux_input_enable_o, loopback_enable_o,
                        bandpass_insert_o};
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    always_ff @(posedge clock_i) begin
        if (reset_i || transmit_frame_sync_n_o) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= low_cnt + 8'h01;
        end
        if (reset_i || !transmit_frame_sync_n_o) begin
            high_cnt <= 8'h00;
        end else if (high_cnt != 8'hff) begin
            high_cnt <= high_cnt + 8'h01;
        end
    end
    property p_reset_ctrl;
        $past(reset_i) |-> ctrl == 6'h39 && !shutdown_o && dac_word_o == 14'h0000;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("reset state wrong");
    property p_shutdown_quiet;
        shutdown_o && $past(shutdown_o) |-> !dac_strobe_o && !adc_strobe_o;
    endproperty
    a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("strobe in shutdown");
    property p_dac_hold;
        $changed(dac_word_o) && !$past(reset_i) |-> $past(dac_strobe_o) or ##[0:1] dac_strobe_o;
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("dac moved");
    property p_frame_len;
        $rose(transmit_frame_sync_n_o) && !$past(reset_i) |-> low_cnt == 8'h40;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length");
    // illegal coarse values shrink the period below a frame pair
    property p_frame_gap;
        $fell(transmit_frame_sync_n_o) && !shutdown_o && !$past(shutdown_o, 8)
            |-> high_cnt >= 8'h10;
    endproperty
    a_frame_gap: assert property (p_frame_gap) else $error("frame gap");
    property p_sync_strobes;
        sync_mode_o && $stable(sync_mode_o) |-> adc_strobe_o == dac_strobe_o;
    endproperty
    a_sync_strobes: assert property (p_sync_strobes) else $error("sync strobes differ");
    property p_sync_rx_frame;
        sync_mode_o && $fell(receive_frame_sync_n_o) |-> $fell(transmit_frame_sync_n_o);
    endproperty
    a_sync_rx_frame: assert property (p_sync_rx_frame) else $error("rx frame alone");
    property p_ctrl_at_frame_end;
        $changed(ctrl) && !$past(reset_i) |-> transmit_frame_sync_n_o && high_cnt < 8'h03;
    endproperty
    a_ctrl_at_frame_end: assert property (p_ctrl_at_frame_end) else $error("ctrl moved");
endmodule
bind codec_conversion_timing_control codec_timing_checker chk (
    .clock_i(clock_i), .reset_i(reset_i), .dac_word_o(dac_word_o),
    .transmit_frame_sync_n_o(transmit_frame_sync_n_o), .shutdown_o(shutdown_o),
    .receive_frame_sync_n_o(receive_frame_sync_n_o), .dac_strobe_o(dac_strobe_o),
    .adc_strobe_o(adc_strobe_o), .bandpass_insert_o(bandpass_insert_o),
    .loopback_enable_o(loopback_enable_o), .aux_input_enable_o(aux_input_enable_o),
    .sync_mode_o(sync_mode_o), .input_gain_o(input_gain_o));
`default_nettype wire

// >>> testbench/host_serial_model.sv
`default_nettype none
module host_serial_model (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        frame_sync_n_i,
    input  wire logic        shift_clock_i,
    input  wire logic [15:0] primary_i,
    input  wire logic [15:0] secondary_i,
    output logic             serial_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] shreg;
    logic        sec_next;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            shreg    <= 16'h0000;
            sec_next <= 1'b0;
            serial_o <= 1'b0;
        end else if ($fell(frame_sync_n_i)) begin
            shreg    <= sec_next ? {secondary_i[14:0], 1'b0} : {primary_i[14:0], 1'b0};
            serial_o <= sec_next ? secondary_i[15] : primary_i[15];
            sec_next <= !sec_next && primary_i[1:0] == 2'h3;
        end else if (!frame_sync_n_i && $rose(shift_clock_i)) begin
            serial_o <= shreg[15];
            shreg    <= {shreg[14:0], 1'b0};
        end else if (frame_sync_n_i) begin
            // idle line wanders
            serial_o <= !serial_o;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/codec_conversion_timing_control_tb.sv
`default_nettype none
module codec_conversion_timing_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i;
    logic        reset_i;
    logic        serial_in;
    logic        shift_clock;
    logic        tx_fs_n;
    logic [13:0] dac_word;
    logic        dac_strobe;
    logic        shutdown;
    logic [5:0]  ctrl;
    logic [15:0] prim_w;
    logic [15:0] sec_w;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          ts;
    int          len;
    codec_conversion_timing_control uut (
        .clock_i(clock_i), .reset_i(reset_i), .serial_word_in_i(serial_in),
        .adc_word_i(16'ha5c3), .shift_clock_o(shift_clock), .transmit_frame_sync_n_o(tx_fs_n),
        .receive_frame_sync_n_o(), .serial_word_out_o(), .dac_word_o(dac_word),
        .dac_strobe_o(dac_strobe), .adc_strobe_o(), .tx_filter_clock_o(),
        .rx_filter_clock_o(), .shutdown_o(shutdown), .bandpass_insert_o(ctrl[0]),
        .loopback_enable_o(ctrl[1]), .aux_input_enable_o(ctrl[2]), .sync_mode_o(ctrl[3]),
        .input_gain_o(ctrl[5:4]));
    host_serial_model host (
        .clock_i(clock_i), .reset_i(reset_i), .frame_sync_n_i(tx_fs_n),
        .shift_clock_i(shift_clock), .primary_i(prim_w), .secondary_i(sec_w),
        .serial_o(serial_in));
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            results();
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_strobe;
        int n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (dac_strobe !== 1'b1 && n < 3000);
        ts = cyc;
        if (n >= 3000) check("strobe", 16'h0001, 16'h0000);
    endtask
    task automatic period(input logic [15:0] prim, input logic [15:0] sec);
        int t0;
        wait_strobe();
        t0 = ts;
        @(posedge clock_i);
        prim_w <= prim;
        sec_w  <= sec;
        wait_strobe();
        len = ts - t0;
        check("dac", {2'h0, prim[15:2]}, {2'h0, dac_word});
        @(posedge clock_i);
        prim_w <= 16'h0000;
    endtask
    task automatic t_reset_and_control;
        check("ctrl", 16'h0039, {10'h000, ctrl});
        period(16'h0000, 16'h0000);
        check("period", 16'h0288, 16'(len));
        period(16'h0003, 16'h007b);
        check("ctrl", 16'h001e, {10'h000, ctrl});
        period(16'h0003, 16'h00e7);
        check("ctrl", 16'h0039, {10'h000, ctrl});
    endtask
    task automatic t_fine;
        period(16'h0003, 16'h1002);
        period(16'h0000, 16'h0000);
        check("period", 16'h0120, 16'(len));
        period(16'h0003, 16'h0102);
        period(16'h0000, 16'h0000);
        check("period", 16'h0288, 16'(len));
    endtask
    task automatic t_trim;
        logic [5:0]  trim [5] = '{6'h02, 6'h3d, 6'h08, 6'h34, 6'h05};
        logic [1:0]  mode [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2};
        logic [15:0] want [5] = '{16'h028a, 16'h0285, 16'h0288, 16'h02bc, 16'h0283};
        for (int i = 0; i < 5; i++) begin
            period(16'h0003, {1'b0, trim[i], 1'b0, trim[i], 2'h1});
            period({12'h5a0, i[1:0], mode[i]}, 16'h0000);
            check("trim", want[i], 16'(len));
        end
        period(16'h0000, 16'h0000);
        check("period", 16'h0288, 16'(len));
    endtask
    task automatic t_shutdown;
        int n;
        wait_strobe();
        @(posedge clock_i);
        prim_w <= 16'h0003;
        sec_w  <= 16'h0000;
        n = 0;
        repeat (1500) begin
            @(negedge clock_i);
            n += int'(dac_strobe === 1'b1);
        end
        check("strobes", 16'h0000, 16'(n));
        check("shutdown", 16'h0001, {15'h0000, shutdown});
        @(posedge clock_i);
        sec_w <= 16'h1224;
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (shutdown !== 1'b0 && n < 3000);
        check("shutdown", 16'h0000, {15'h0000, shutdown});
        period(16'h0000, 16'h0000);
        period(16'h0000, 16'h0000);
        check("period", 16'h0288, 16'(len));
    endtask
    initial begin
        reset_i = 1'b1;
        prim_w  = 16'h0000;
        sec_w   = 16'h0000;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        t_reset_and_control();
        t_fine();
        t_trim();
        t_shutdown();
        results();
    end
endmodule
`default_nettype wire
